// ==== dv/adc_serial_command_port_tb.sv ====
// self-checking bench for the converter's serial command port
`timescale 1ns/1ns

module adc_serial_command_port_tb;
	typedef struct packed {
		logic [3:0] cmd;
		logic       pol;
		logic       dsp;
		logic [9:0] word;
	} row_t;
	logic       ref_clk = 1'h0;
	logic       rst = 1'h1;
	logic       coreValid = 1'h0;
	logic [9:0] coreData = 10'h000;
	logic       csN;
	logic       ioClk;
	logic       dataIn;
	logic       frameSync;
	logic       cps;
	logic       dataOut;
	logic       dataOutEn;
	logic       convDone;
	logic       sampling;
	logic       convStart;
	logic [2:0] convChannel;
	logic       powerDown;
	logic       slowRate;
	logic       micoMode;
	logic       coreReady;
	logic [9:0] prevRes;
	logic [2:0] expChan;
	logic       expSlow;
	int         err_total = 0;
	int         n_checks = 0;
	int         cyc = 0;
	int         convCnt = 0;
	int         sampCnt = 0;
	// command, polarity, dsp mode, word queued or self-test value
	row_t rows [17] = '{
		'{4'h9, 1'h1, 1'h0, 10'h000}, '{4'h1, 1'h1, 1'h0, 10'h155},
		'{4'h2, 1'h0, 1'h0, 10'h2aa}, '{4'hb, 1'h0, 1'h1, 10'h200},
		'{4'h8, 1'h1, 1'h1, 10'h000}, '{4'h3, 1'h1, 1'h1, 10'h0f0},
		'{4'ha, 1'h0, 1'h0, 10'h000}, '{4'h8, 1'h0, 1'h0, 10'h000},
		'{4'hd, 1'h1, 1'h0, 10'h3ff}, '{4'h4, 1'h0, 1'h1, 10'h30c},
		'{4'he, 1'h1, 1'h0, 10'h000}, '{4'h5, 1'h0, 1'h0, 10'h001},
		'{4'hf, 1'h1, 1'h1, 10'h000}, '{4'h6, 1'h1, 1'h0, 10'h3fe},
		'{4'hc, 1'h0, 1'h1, 10'h000}, '{4'h7, 1'h0, 1'h0, 10'h2c3},
		'{4'h0, 1'h1, 1'h1, 10'h1e1}
	};

	always #10 ref_clk = ~ref_clk;

	adc_serial_command_port i_dut (
		.ref_clk(ref_clk), .rst(rst), .csN(csN), .ioClk(ioClk), .dataIn(dataIn),
		.frameSync(frameSync), .clockPolaritySelect(cps), .dataOut(dataOut),
		.dataOutEn(dataOutEn), .convDone(convDone), .sampling(sampling),
		.convStart(convStart), .convChannel(convChannel), .powerDown(powerDown),
		.slowRate(slowRate), .micoMode(micoMode), .coreValid(coreValid),
		.coreReady(coreReady), .coreData(coreData)
	);

	host_model h (
		.ref_clk(ref_clk), .csN(csN), .ioClk(ioClk), .dataIn(dataIn),
		.frameSync(frameSync), .clockPolaritySelect(cps), .dataOut(dataOut),
		.dataOutEn(dataOutEn)
	);

	// count start pulses; a hang is cut short by the cycle ceiling
	always @(posedge ref_clk)
	begin
		cyc <= cyc + 1;
		if (convStart === 1'h1)
			convCnt <= convCnt + 1;
		if (sampling === 1'h1)
			sampCnt <= sampCnt + 1;
		if (cyc == 30000)
		begin
			err_total++;
			test_done();
		end
	end

	task automatic cmp(input string nm, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("BAD %s exp %h got %h", nm, exp, got);
		end
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic resetDut();
		rst <= 1'h1;
		repeat (6) @(posedge ref_clk);
		rst <= 1'h0;
		@(posedge ref_clk);
		cmp("reset", 16'h0203, 16'({dataOut, dataOutEn, convDone, sampling, convStart,
			convChannel, powerDown, slowRate, micoMode, coreReady}));
		prevRes = adc_port_pkg::RESULT_RST;
		expChan = 3'h0;
		expSlow = 1'h0;
		$display("reset done");
	endtask

	// one frame, then every side effect it should leave behind
	task automatic run(input logic [3:0] cmd, input logic pol, input logic dsp,
		input int nClk, input logic [9:0] word, input logic push);
		logic [15:0] rd;
		logic [15:0] mask;
		logic        en;
		logic        conv;
		int          c0;
		int          s0;
		int          t;
		conv = nClk >= 10 && (cmd < 4'h8 || (cmd > 4'ha && cmd < 4'he));
		mask = 16'hffff << (16 - nClk);
		if (push && conv && cmd < 4'h8)
		begin
			@(posedge ref_clk);
			coreValid <= 1'h1;
			coreData <= word;
			@(posedge ref_clk);
			coreValid <= 1'h0;
		end
		c0 = convCnt;
		s0 = sampCnt;
		h.xfer(dsp, pol, cmd, nClk, rd, en);
		cmp("rd", {prevRes, 6'h00} & mask, rd);
		cmp("en", 16'h0001, 16'(en));
		cmp("off", 16'h0000, 16'(dataOutEn));
		// self-test runs internally, only channel codes start the core
		cmp("conv", 16'(conv && cmd < 4'h8), 16'(convCnt - c0));
		if (conv && cmd > 4'h8)
			cmp("busy", 16'h0000, 16'(convDone));
		if (nClk >= 10)
		begin
			if (conv)
				prevRes = word;
			if (cmd < 4'h8)
				expChan = cmd[2:0];
			if (cmd == 4'h9)
				expSlow = 1'h0;
			if (cmd == 4'ha)
				expSlow = 1'h1;
			cmp("chan", 16'(expChan), 16'(convChannel));
			// window is six link periods of eight system clocks
			cmp("samp", 16'h0030, 16'(sampCnt - s0));
		end
		cmp("pd", 16'(nClk >= 10 && cmd == 4'h8), 16'(powerDown));
		cmp("slow", 16'(expSlow), 16'(slowRate));
		cmp("mode", 16'(!dsp), 16'(micoMode));
		t = 0;
		while (convDone !== 1'h1 && t < 3000)
		begin
			@(posedge ref_clk);
			t++;
		end
		cmp("done", 16'h0001, 16'(convDone));
		if (conv && cmd > 4'h8)
			cmp("time", 16'(expSlow), 16'(t > 1000));
	endtask

	initial
	begin
		resetDut();
		for (int r = 0; r < 17; r++)
		begin
			run(rows[r].cmd, rows[r].pol, rows[r].dsp, 16, rows[r].word, 1'h1);
			$display("row %0d done", r);
		end
		// select lifted after five clocks, then a minimum ten-clock frame
		run(4'h3, 1'h1, 1'h0, 5, 10'h000, 1'h0);
		run(4'h0, 1'h0, 1'h0, 10, 10'h0a5, 1'h1);
		$display("abort done");
		// fill back to back until refused, then drain through conversions
		for (int k = 0; k < 9; k++)
		begin
			@(posedge ref_clk);
			coreValid <= 1'h1;
			coreData <= 10'(k * 73 + 5);
		end
		@(posedge ref_clk);
		coreValid <= 1'h0;
		@(posedge ref_clk);
		cmp("full", 16'h0000, 16'(coreReady));
		for (int k = 0; k < 8; k++)
			run(4'(k), 1'(k), 1'(k >> 1), 16, 10'(k * 73 + 5), 1'h0);
		cmp("empty", 16'h0001, 16'(coreReady));
		$display("fifo done");
		resetDut();
		run(4'h2, 1'h1, 1'h1, 16, 10'h1c7, 1'h1);
		$display("rerun done");
		test_done();
	end
endmodule // adc_serial_command_port_tb

// ==== dv/host_model.sv ====
// host side model: select, serial clock, frame sync and command bits
`timescale 1ns/1ns

module host_model (
	input  wire logic ref_clk,
	output logic      csN,
	output logic      ioClk,
	output logic      dataIn,
	output logic      frameSync,
	output logic      clockPolaritySelect,
	input  wire logic dataOut,
	input  wire logic dataOutEn
);
	logic busy = 1'h0;

	// pins idle: select high, clock still low
	initial
	begin
		csN = 1'h1;
		ioClk = 1'h0;
		dataIn = 1'h0;
		frameSync = 1'h1;
		clockPolaritySelect = 1'h1;
	end

	// released data line wanders so a stale bit never passes for a command
	always @(posedge ref_clk)
		if (!busy)
			dataIn <= ~dataIn;

	// one frame; capture on lead edge when pol is high, output on trail edge
	task automatic xfer(input logic dsp, input logic pol, input logic [3:0] cmd,
		input int nClk, output logic [15:0] rd, output logic en);
		int i;
		rd = 16'h0000;
		en = 1'h1;
		@(posedge ref_clk);
		busy <= 1'h1;
		clockPolaritySelect <= pol;
		frameSync <= ~dsp;
		repeat (2) @(posedge ref_clk);
		csN <= 1'h0;
		repeat (6) @(posedge ref_clk);
		if (dsp)
		begin
			frameSync <= 1'h1;
			ioClk <= 1'h1;
			repeat (4) @(posedge ref_clk);
			ioClk <= 1'h0;
			repeat (4) @(posedge ref_clk);
			ioClk <= 1'h1;
			repeat (2) @(posedge ref_clk);
			frameSync <= 1'h0;
			repeat (6) @(posedge ref_clk);
		end
		for (i = 0; i < 2 * nClk; i++)
		begin
			repeat (2) @(posedge ref_clk);
			if (i[0] != pol && i < 8)
				dataIn <= cmd[3 - i / 2];
			if (i[0])
				rd[15 - i / 2] = dataOut;
			en &= dataOutEn;
			repeat (2) @(posedge ref_clk);
			ioClk <= ~ioClk;
		end
		repeat (4) @(posedge ref_clk);
		csN <= 1'h1;
		repeat (4) @(posedge ref_clk);
		ioClk <= 1'h0;
		frameSync <= 1'h1;
		busy <= 1'h0;
	endtask
endmodule // host_model

// ==== inc/adc_port_pkg.sv ====
// shared constants for the serial command port of the converter
package adc_port_pkg;
	localparam int CLK_HZ = 50_000_000;
	localparam int FAST_NS = 10_000;
	localparam int SLOW_NS = 40_000;
	localparam int FAST_CYC = FAST_NS / (1_000_000_000 / CLK_HZ);
	localparam int SLOW_CYC = SLOW_NS / (1_000_000_000 / CLK_HZ);
	localparam int TMR_W = 12;
	localparam int CNT_W = 5;
	localparam int CMD_W = 4;
	localparam logic [CNT_W-1:0] CNT_RST = 5'h00;
	localparam logic [CNT_W-1:0] CNT_MAX = 5'h1f;
	// pre-increment counts of the fourth and tenth edges
	localparam logic [CNT_W-1:0] EDGE_4TH = 5'h03;
	localparam logic [CNT_W-1:0] EDGE_10TH = 5'h09;
	localparam logic [CMD_W-1:0] CMD_RST = 4'h0;
	localparam logic [CMD_W-1:0] CMD_PWRDN = 4'h8;
	localparam logic [CMD_W-1:0] CMD_FAST = 4'h9;
	localparam logic [CMD_W-1:0] CMD_SLOW = 4'ha;
	localparam logic [CMD_W-1:0] CMD_ST_MID = 4'hb;
	localparam logic [CMD_W-1:0] CMD_ST_LO = 4'hc;
	localparam logic [CMD_W-1:0] CMD_ST_HI = 4'hd;
	localparam logic [9:0] ST_MID_VAL = 10'h200;
	localparam logic [9:0] ST_LO_VAL = 10'h000;
	localparam logic [9:0] ST_HI_VAL = 10'h3ff;
	localparam logic [9:0] RESULT_RST = 10'h000;
	localparam logic [2:0] CHAN_RST = 3'h0;
	typedef enum logic [1:0] {CONV_IDLE, CONV_CORE, CONV_SELF} conv_state_t;
endpackage

// ==== verilog/adc_serial_command_port.sv ====
// serial command and readout port of a 10-bit converter, with result fifo
// Function
// - latch frame sync into mode at select fall
// - micro mode captures command on polarity edge
// - micro mode shows result msb at select fall
// - remaining nine bits follow on next edges
// - done goes low at tenth edge, conversion starts
// - output forced low from tenth shift edge
// - driver on at select fall, off at rise
// - select change aborts cycle, result kept
// - dsp mode shifts result on rising edges
// - dsp mode captures command on opposite edges
// - dsp sequencer resets while frame sync high
// - dsp frames pad six trailing zero bits
// - select rise clears counter, resets, disables port
// - sampling starts at fourth edge of frame
// - dsp conversion starts at tenth falling edge
// - four-bit command register, msb first
// - codes zero to seven pick channel
// - code eight enters power-down, any access clears
// - codes nine and ten set conversion rate
// - rate persists across power-down
// - self-test codes give fixed results
`timescale 1ns/1ns

module result_fifo #(
	parameter int W = 10,
	parameter int D = 8
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         inValid,
	output logic              inReady,
	input  wire logic [W-1:0] inData,
	output logic              outValid,
	input  wire logic         outReady,
	output logic      [W-1:0] outData
);
	localparam int AW = $clog2(D);
	initial if (D < 2 || (1 << AW) != D) $error("fifo depth must be a power of two");
	logic [W-1:0] mem [D];
	logic [AW:0]  wrPtr_q;
	logic [AW:0]  rdPtr_q;
	wire          push = inValid && inReady;
	wire          pop = outValid && outReady;
	// full when pointers differ only in the wrap bit
	assign inReady = !((wrPtr_q[AW] != rdPtr_q[AW]) && (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]));
	assign outValid = wrPtr_q != rdPtr_q;
	assign outData = mem[rdPtr_q[AW-1:0]];
	// pointer update; a refused push or an empty pop adds zero
	always_ff @(posedge clk)
	begin
		wrPtr_q <= rst ? '0 : wrPtr_q + (AW+1)'(push);
		rdPtr_q <= rst ? '0 : rdPtr_q + (AW+1)'(pop);
	end
	// storage has no reset, only valid words are read
	always_ff @(posedge clk)
	begin
		if (push)
			mem[wrPtr_q[AW-1:0]] <= inData;
	end
endmodule // result_fifo

module adc_serial_command_port #(
	parameter int RES_W = 10,
	parameter int FIFO_D = 8
) (
	input  wire logic             ref_clk,
	input  wire logic             rst,
	input  wire logic             csN,
	input  wire logic             ioClk,
	input  wire logic             dataIn,
	input  wire logic             frameSync,
	input  wire logic             clockPolaritySelect,
	output logic                  dataOut,
	output logic                  dataOutEn,
	output logic                  convDone,
	output logic                  sampling,
	output logic                  convStart,
	output logic      [2:0]       convChannel,
	output logic                  powerDown,
	output logic                  slowRate,
	output logic                  micoMode,
	input  wire logic             coreValid,
	output logic                  coreReady,
	input  wire logic [RES_W-1:0] coreData
);
	initial if (RES_W != 10) $error("result width must be ten");
	// saturating edge count
	function automatic logic [4:0] incSat(input logic [4:0] v);
		return (v == adc_port_pkg::CNT_MAX) ? v : 5'(v + 5'h01);
	endfunction
	// two-stage synchronisers, third stage only for edge finding
	logic [1:0] csS_q;
	logic [1:0] ckS_q;
	logic [1:0] dinS_q;
	logic [1:0] fsS_q;
	logic [1:0] polS_q;
	logic       csD_q;
	logic       ckD_q;
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			csS_q <= 2'h3;
			ckS_q <= 2'h0;
			dinS_q <= 2'h0;
			fsS_q <= 2'h3;
			polS_q <= 2'h0;
			csD_q <= 1'b1;
			ckD_q <= 1'b0;
		end
		else
		begin
			csS_q <= {csS_q[0], csN};
			ckS_q <= {ckS_q[0], ioClk};
			dinS_q <= {dinS_q[0], dataIn};
			fsS_q <= {fsS_q[0], frameSync};
			polS_q <= {polS_q[0], clockPolaritySelect};
			csD_q <= csS_q[1];
			ckD_q <= ckS_q[1];
		end
	end
	logic                    ifMode_q;
	logic                    dspArmed_q;
	logic                    dspRun_q;
	logic [4:0]              riseCnt_q;
	logic [4:0]              fallCnt_q;
	logic [3:0]              cmd_q;
	logic [RES_W-1:0]        shift_q;
	logic [RES_W-1:0]        result_q;
	logic [adc_port_pkg::TMR_W-1:0] tmr_q;
	adc_port_pkg::conv_state_t     st_q;
	// edge and frame decode
	wire csLow = !csS_q[1];
	wire fsHi = fsS_q[1];
	wire csFall = csD_q && !csS_q[1];
	wire csRise = !csD_q && csS_q[1];
	wire riseEv = ckS_q[1] && !ckD_q;
	wire fallEv = !ckS_q[1] && ckD_q;
	wire dspMode = csLow && !ifMode_q;
	wire dspRst = dspMode && fallEv && fsHi;
	wire dspStart = dspMode && dspArmed_q && riseEv;
	wire microStart = csFall && fsHi;
	wire frameStart = microStart || dspStart;
	wire running = csLow && (ifMode_q || dspRun_q);
	// command capture edge: micro rise when polarity high, dsp the opposite
	wire capRise = ifMode_q == polS_q[1];
	wire capEv = running && (capRise ? riseEv : fallEv);
	wire [4:0] capCnt = capRise ? riseCnt_q : fallCnt_q;
	wire capOn = capEv && (capCnt <= adc_port_pkg::EDGE_4TH);
	wire [3:0] cmdNext = {cmd_q[2:0], dinS_q[1]};
	wire cmdLast = capEv && (capCnt == adc_port_pkg::EDGE_4TH);
	// sample and convert edges: micro rising, dsp falling
	wire seqEv = running && (ifMode_q ? riseEv : fallEv);
	wire [4:0] seqCnt = ifMode_q ? riseCnt_q : fallCnt_q;
	wire sampEv = seqEv && (seqCnt == adc_port_pkg::EDGE_4TH);
	wire convEv = seqEv && (seqCnt == adc_port_pkg::EDGE_10TH);
	wire shEv = running && (ifMode_q ? fallEv : riseEv);
	wire isChan = !cmd_q[3];
	wire isSelf = (cmd_q >= adc_port_pkg::CMD_ST_MID) && (cmd_q <= adc_port_pkg::CMD_ST_HI);
	wire [RES_W-1:0] selfVal = (cmd_q == adc_port_pkg::CMD_ST_MID) ? adc_port_pkg::ST_MID_VAL :
		(cmd_q == adc_port_pkg::CMD_ST_LO) ? adc_port_pkg::ST_LO_VAL : adc_port_pkg::ST_HI_VAL;
	wire [adc_port_pkg::TMR_W-1:0] convCyc = slowRate ?
		adc_port_pkg::TMR_W'(adc_port_pkg::SLOW_CYC) :
		adc_port_pkg::TMR_W'(adc_port_pkg::FAST_CYC);
	wire fifoValid;
	wire [RES_W-1:0] fifoData;
	wire fifoPop = st_q == adc_port_pkg::CONV_CORE;
	// the drain stalls outside a core conversion, so the fifo can fill
	result_fifo #(.W(RES_W), .D(FIFO_D)) resultBuf (
		.clk      (ref_clk),
		.rst      (rst),
		.inValid  (coreValid),
		.inReady  (coreReady),
		.inData   (coreData),
		.outValid (fifoValid),
		.outReady (fifoPop),
		.outData  (fifoData)
	);
	assign dataOut = shift_q[RES_W-1];
	assign micoMode = ifMode_q;
	// mode flag, dsp arm/run and driver enable; a select fall always wins
	always_ff @(posedge ref_clk)
	begin
		ifMode_q <= rst || (csFall ? fsHi : ifMode_q);
		dspArmed_q <= !rst && !csFall && !dspStart && (dspRst || dspArmed_q);
		dspRun_q <= !rst && !csFall && !dspRst && (dspStart || dspRun_q);
		dataOutEn <= !rst && !csRise && (csFall || dataOutEn);
	end
	// edge counters; a select rise aborts the frame, counts restart
	always_ff @(posedge ref_clk)
	begin
		if (rst || csRise || frameStart || dspRst)
		begin
			riseCnt_q <= adc_port_pkg::CNT_RST;
			fallCnt_q <= adc_port_pkg::CNT_RST;
		end
		else if (running)
		begin
			if (riseEv)
				riseCnt_q <= incSat(riseCnt_q);
			if (fallEv)
				fallCnt_q <= incSat(fallCnt_q);
		end
	end
	// command register, msb first, and its decoded settings
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			cmd_q <= adc_port_pkg::CMD_RST;
			convChannel <= adc_port_pkg::CHAN_RST;
			powerDown <= 1'b0;
			slowRate <= 1'b0;
		end
		else
		begin
			if (capOn)
				cmd_q <= cmdNext;
			if (cmdLast && !cmdNext[3])
				convChannel <= cmdNext[2:0];
			if (cmdLast && cmdNext == adc_port_pkg::CMD_PWRDN)
				powerDown <= 1'b1;
			else if (csFall)
				powerDown <= 1'b0;
			if (cmdLast && cmdNext == adc_port_pkg::CMD_FAST)
				slowRate <= 1'b0;
			else if (cmdLast && cmdNext == adc_port_pkg::CMD_SLOW)
				slowRate <= 1'b1;
		end
	end
	// output shifter: loaded at frame start, zeros shift in behind
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			shift_q <= adc_port_pkg::RESULT_RST;
		else if (frameStart)
			shift_q <= result_q;
		else if (shEv)
			shift_q <= {shift_q[RES_W-2:0], 1'b0};
	end
	// sampling window and conversion sequencer
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			sampling <= 1'b0;
			convStart <= 1'b0;
			convDone <= 1'b1;
			st_q <= adc_port_pkg::CONV_IDLE;
			tmr_q <= '0;
			result_q <= adc_port_pkg::RESULT_RST;
		end
		else
		begin
			convStart <= 1'b0;
			if (convEv || csRise || dspRst || frameStart)
				sampling <= 1'b0;
			else if (sampEv)
				sampling <= 1'b1;
			unique case (st_q)
				adc_port_pkg::CONV_IDLE:
				begin
					if (convEv && isChan)
					begin
						convStart <= 1'b1;
						convDone <= 1'b0;
						st_q <= adc_port_pkg::CONV_CORE;
					end
					else if (convEv && isSelf)
					begin
						convDone <= 1'b0;
						tmr_q <= convCyc;
						st_q <= adc_port_pkg::CONV_SELF;
					end
				end
				adc_port_pkg::CONV_CORE:
				begin
					if (fifoValid)
					begin
						result_q <= fifoData;
						convDone <= 1'b1;
						st_q <= adc_port_pkg::CONV_IDLE;
					end
				end
				adc_port_pkg::CONV_SELF:
				begin
					if (tmr_q <= 12'h001)
					begin
						result_q <= selfVal;
						convDone <= 1'b1;
						st_q <= adc_port_pkg::CONV_IDLE;
					end
					else
						tmr_q <= tmr_q - 12'h001;
				end
			endcase
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	mode_latch_a: assert property (csFall |=> ifMode_q == $past(fsHi))
		else $error("mode flag not latched from frame sync");
	cmd_shift_a: assert property (capOn |=> cmd_q == $past(cmdNext))
		else $error("command bit not captured");
	msb_first_a: assert property (microStart |=> dataOut == $past(result_q[9]))
		else $error("result msb not shown at select fall");
	eoc_low_a: assert property (convEv && isChan && st_q == adc_port_pkg::CONV_IDLE
		|=> !convDone && convStart)
		else $error("done not lowered at tenth edge");
	zero_fill_a: assert property (running && ifMode_q && fallCnt_q >= 5'h0a
		&& !frameStart |-> !dataOut)
		else $error("output not zero after tenth shift");
	drv_off_a: assert property (csRise |=> !dataOutEn ##1 !dataOutEn)
		else $error("driver stays on after select rise");
	dsp_reset_a: assert property (dspRst |=> !dspRun_q && riseCnt_q == 5'h00)
		else $error("dsp sequencer not reset");
	pwr_down_a: assert property (cmdLast && cmdNext == adc_port_pkg::CMD_PWRDN
		|=> powerDown)
		else $error("power-down not entered");
	self_mid_a: assert property ($rose(convDone) && st_q == adc_port_pkg::CONV_IDLE
		&& $past(st_q) == adc_port_pkg::CONV_SELF && cmd_q == adc_port_pkg::CMD_ST_MID
		|-> result_q == 10'h200)
		else $error("mid self-test result wrong");
	micro_conv_c: cover property (convStart && ifMode_q);
	dsp_conv_c: cover property (convStart && !ifMode_q);
	self_test_c: cover property (st_q == adc_port_pkg::CONV_SELF ##1 convDone);
	fifo_full_c: cover property (!coreReady);
endmodule // adc_serial_command_port
